// ---- rtl/ccfm_defs.svh ----
// Constants for the crystal clock failure monitor
`ifndef CCFM_DEFS_SVH
`define CCFM_DEFS_SVH

// Safe clock periods in one monitor window
`define CCFM_MONITOR_TICKS      4
// Width of the monitor window counter
`define CCFM_WINDOW_CNT_W       3
// Width of the start-up time selector
`define CCFM_TIME_SELECT_A_SEL_W      4
// Width of the start-up counter in safe clock periods
`define CCFM_TIME_SELECT_A_CNT_W      16
// Prescaler setting that passes the safe oscillator undivided
`define CCFM_PRESC_DIV1         1'b0
// Prescaler setting that divides the safe oscillator by two
`define CCFM_PRESC_DIV2         1'b1
// Synchroniser depth for pin inputs
`define CCFM_SYNC_STAGES        2
// Reset level and the one that the start-up limit is shifted from
`define CCFM_FLAG_RESET         1'b0
`define CCFM_CNT_ONE            16'h0001

`endif

// ---- rtl/ccfm_pkg.sv ----
// Types for the crystal clock failure monitor
package ccfm_pkg;

  // Which source drives the 32 kHz and 1 kHz outputs
  typedef enum logic [1:0] {
    ccfm_on_crystal = 2'b01,
    ccfm_on_safe    = 2'b10
  } ccfm_switch_state_type;

  // Start-up supervision of the crystal
  typedef enum logic [2:0] {
    ccfm_osc_off      = 3'b001,
    ccfm_osc_starting = 3'b010,
    ccfm_osc_running  = 3'b100
  } ccfm_time_select_a_state_type;

endpackage

// ---- rtl/ccfm_sync.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps

module ccfm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  if (WIDTH < 1) begin : g_bad_width
    $error("ccfm_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// ---- rtl/ccfm_presc.sv ----
// Safe clock prescaler for the 32 kHz and 1 kHz safe oscillator outputs
`timescale 1ns/100ps
`include "ccfm_defs.svh"

module ccfm_presc (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic safe_32k_in,
  input  wire logic safe_1k_in,
  input  wire logic safe_clock_prescale,
  output logic      safe_32k_out,
  output logic      safe_1k_out,
  output logic      safe_tick
);

  logic [1:0] prev_in;
  logic [1:0] half_clk;
  logic [1:0] rise_in;
  logic [1:0] raw_in;
  logic       prev_32k_out;
  logic       next_32k_out;

  assign raw_in  = {safe_1k_in, safe_32k_in};
  assign rise_in = raw_in & ~prev_in;

  // Divide-by-two copies of both outputs
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_half
      always_ff @(posedge core_clk) begin
        if (!rst_b) begin
          prev_in[i]  <= `CCFM_FLAG_RESET;
          half_clk[i] <= `CCFM_FLAG_RESET;
        end else begin
          prev_in[i] <= raw_in[i];
          if (rise_in[i]) begin
            half_clk[i] <= ~half_clk[i];
          end
        end
      end
    end
  endgenerate

  // Same division on both safe outputs
  assign next_32k_out = (safe_clock_prescale == `CCFM_PRESC_DIV2) ?
                        half_clk[0] : safe_32k_in;
  assign safe_1k_out  = (safe_clock_prescale == `CCFM_PRESC_DIV2) ?
                        half_clk[1] : safe_1k_in;
  assign safe_32k_out = next_32k_out;

  // One pulse per rising edge of the scaled safe clock
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prev_32k_out <= `CCFM_FLAG_RESET;
    end else begin
      prev_32k_out <= next_32k_out;
    end
  end

  assign safe_tick = next_32k_out & ~prev_32k_out;

endmodule

// ---- rtl/ccfm_top.sv ----
// Crystal clock failure monitor with safe clock switch-over
// Behaviour
// - Fail status and window clear on power-on reset or when monitoring is off.
// - Crystal disabled: no monitoring and no failure reports.
// - Detection starts when the detector enable bit is one.
// - After crystal start, wait the start-up time, then monitor always.
// - Each four-safe-period window needs a crystal rise and fall.
// - A failure sets the fail status bit and fail interrupt flag.
// - A failure raises an interrupt when its enable bit is one.
// - A failure emits an output event when event enable is set.
// - Monitoring continues; fail status follows present crystal activity.
// - On failure, safe 32 kHz and 1 kHz replace crystal outputs.
// - Clock switched status bit is set when safe clock is used.
// - Switching does not disable the crystal oscillator.
// - Switch back request is cleared by hardware when done.
// - Safe clock comes through a prescaler, largest factor two.
// - The prescaler applies to both safe outputs.
// - Prescale setting zero passes the safe oscillator undivided.
`timescale 1ns/100ps
`include "ccfm_defs.svh"

module ccfm_top #(
  parameter int MONITOR_TICKS = `CCFM_MONITOR_TICKS,
  parameter int TIME_SELECT_A_SEL_W = `CCFM_TIME_SELECT_A_SEL_W,
  parameter int TIME_SELECT_A_CNT_W = `CCFM_TIME_SELECT_A_CNT_W
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst_b,
  input  wire logic                     crystal_32k_osc_clk,
  input  wire logic                     crystal_1k_clk,
  input  wire logic                     low_power_safe_osc_32k,
  input  wire logic                     low_power_safe_osc_1k,
  input  wire logic                     crystal_enable,
  input  wire logic                     crystal_restart,
  input  wire logic [TIME_SELECT_A_SEL_W-1:0] time_select_a,
  input  wire logic                     detector_enable,
  input  wire logic                     safe_clock_prescale,
  input  wire logic                     interrupt_enable_set_reg,
  input  wire logic                     failure_event_out_enable,
  input  wire logic                     interrupt_flag_clear,
  input  wire logic                     switch_back_write,
  output logic                          crystal_fail_flag,
  output logic                          interrupt_flag_reg,
  output logic                          fail_irq,
  output logic                          fail_event,
  output logic                          clock_switched_flag,
  output logic                          switch_back_request,
  output logic                          crystal_osc_running,
  output logic                          clk_32k_out,
  output logic                          clk_1k_out
);

  // Window length must fit its counter; largest shift of the start-up limit must stay inside the counter
  if (MONITOR_TICKS < 2 ||
      MONITOR_TICKS >= (1 << `CCFM_WINDOW_CNT_W)) begin : g_bad_ticks
    $error("ccfm_top: MONITOR_TICKS out of range");
  end
  if (TIME_SELECT_A_SEL_W < 1 ||
      (1 << TIME_SELECT_A_SEL_W) > TIME_SELECT_A_CNT_W) begin : g_bad_time_select_a
    $error("ccfm_top: TIME_SELECT_A_SEL_W does not fit TIME_SELECT_A_CNT_W");
  end

  localparam logic [`CCFM_WINDOW_CNT_W-1:0] WINDOW_LAST =
    `CCFM_WINDOW_CNT_W'(MONITOR_TICKS - 1);

  // Synchronised pin levels
  logic [3:0] pins_sync;
  logic       xtal_32k;
  logic       xtal_1k;
  logic       safe_32k_raw;
  logic       safe_1k_raw;

  // Scaled safe clock
  logic       safe_32k;
  logic       safe_1k;
  logic       safe_tick;

  // Crystal edge tracking
  logic       xtal_prev;
  logic       xtal_rise;
  logic       xtal_fall;
  logic       seen_rise;
  logic       seen_fall;

  // Monitor window
  logic [`CCFM_WINDOW_CNT_W-1:0] window_cnt;
  logic                          window_end;
  logic                          window_bad;
  logic                          fail_now;
  logic                          monitor_on;

  // Start-up supervision
  ccfm_pkg::ccfm_time_select_a_state_type time_select_a_state;
  logic [TIME_SELECT_A_CNT_W-1:0]         time_select_a_cnt;
  logic [TIME_SELECT_A_CNT_W-1:0]         time_select_a_limit;
  logic                             xtal_en_prev;
  logic                             osc_start;

  // Switch-over
  ccfm_pkg::ccfm_switch_state_type switch_state;
  logic                            switch_back_done;

  ccfm_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in ({low_power_safe_osc_1k, low_power_safe_osc_32k,
                crystal_1k_clk, crystal_32k_osc_clk}),
    .sync_out (pins_sync)
  );

  assign xtal_32k     = pins_sync[0];
  assign xtal_1k      = pins_sync[1];
  assign safe_32k_raw = pins_sync[2];
  assign safe_1k_raw  = pins_sync[3];

  ccfm_presc u_presc (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .safe_32k_in         (safe_32k_raw),
    .safe_1k_in          (safe_1k_raw),
    .safe_clock_prescale (safe_clock_prescale),
    .safe_32k_out        (safe_32k),
    .safe_1k_out         (safe_1k),
    .safe_tick           (safe_tick)
  );

  // Crystal edges on the synchronised level
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      xtal_prev <= `CCFM_FLAG_RESET;
    end else begin
      xtal_prev <= xtal_32k;
    end
  end

  assign xtal_rise = xtal_32k & ~xtal_prev;
  assign xtal_fall = ~xtal_32k & xtal_prev;

  // Start or restart of the crystal oscillator
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      xtal_en_prev <= `CCFM_FLAG_RESET;
    end else begin
      xtal_en_prev <= crystal_enable;
    end
  end

  assign osc_start = crystal_enable & (~xtal_en_prev | crystal_restart);

  // Start-up time in safe clock periods is two to the selected power
  assign time_select_a_limit = TIME_SELECT_A_CNT_W'(`CCFM_CNT_ONE) << time_select_a;

  // Start-up supervision; power-on reset or a disabled crystal clears it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      time_select_a_state <= ccfm_pkg::ccfm_osc_off;
      time_select_a_cnt   <= '0;
    end else if (!crystal_enable) begin
      time_select_a_state <= ccfm_pkg::ccfm_osc_off;
      time_select_a_cnt   <= '0;
    end else if (osc_start) begin
      time_select_a_state <= ccfm_pkg::ccfm_osc_starting;
      time_select_a_cnt   <= '0;
    end else begin
      unique case (time_select_a_state)
        ccfm_pkg::ccfm_osc_off: begin
          time_select_a_state <= ccfm_pkg::ccfm_osc_starting;
          time_select_a_cnt   <= '0;
        end
        ccfm_pkg::ccfm_osc_starting: begin
          if (safe_tick) begin
            if (time_select_a_cnt == time_select_a_limit - TIME_SELECT_A_CNT_W'(1)) begin
              time_select_a_state <= ccfm_pkg::ccfm_osc_running;
            end
            time_select_a_cnt <= time_select_a_cnt + TIME_SELECT_A_CNT_W'(1);
          end
        end
        ccfm_pkg::ccfm_osc_running: begin
          time_select_a_cnt <= time_select_a_cnt;
        end
      endcase
    end
  end

  assign crystal_osc_running = (time_select_a_state == ccfm_pkg::ccfm_osc_running);

  // Detection runs only when enabled and the crystal is up
  assign monitor_on = detector_enable & crystal_enable &
                      crystal_osc_running;

  // Window of safe clock periods
  assign window_end = monitor_on & safe_tick & (window_cnt == WINDOW_LAST);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      window_cnt <= '0;
    end else if (!monitor_on) begin
      window_cnt <= '0;
    end else if (safe_tick) begin
      if (window_cnt == WINDOW_LAST) begin
        window_cnt <= '0;
      end else begin
        window_cnt <= window_cnt + `CCFM_WINDOW_CNT_W'(1);
      end
    end
  end

  // Edge activity seen in the current window
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      seen_rise <= `CCFM_FLAG_RESET;
      seen_fall <= `CCFM_FLAG_RESET;
    end else if (!monitor_on || window_end) begin
      seen_rise <= `CCFM_FLAG_RESET;
      seen_fall <= `CCFM_FLAG_RESET;
    end else begin
      seen_rise <= seen_rise | xtal_rise;
      seen_fall <= seen_fall | xtal_fall;
    end
  end

  // Edges in the closing cycle still count
  assign window_bad = ~((seen_rise | xtal_rise) & (seen_fall | xtal_fall));
  assign fail_now   = window_end & window_bad;

  // Status follows the last finished window
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      crystal_fail_flag <= `CCFM_FLAG_RESET;
    end else if (!monitor_on) begin
      crystal_fail_flag <= `CCFM_FLAG_RESET;
    end else if (window_end) begin
      crystal_fail_flag <= window_bad;
    end
  end

  // Sticky interrupt flag; a new failure beats a clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      interrupt_flag_reg <= `CCFM_FLAG_RESET;
    end else if (fail_now) begin
      interrupt_flag_reg <= 1'b1;
    end else if (interrupt_flag_clear) begin
      interrupt_flag_reg <= `CCFM_FLAG_RESET;
    end
  end

  assign fail_irq = interrupt_flag_reg & interrupt_enable_set_reg;

  // One-cycle event per failed window
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fail_event <= `CCFM_FLAG_RESET;
    end else begin
      fail_event <= fail_now & failure_event_out_enable;
    end
  end

  // Source selection; crystal enable is never touched here
  assign switch_back_done = (switch_state == ccfm_pkg::ccfm_on_safe) &
                            switch_back_request & ~fail_now;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      switch_state <= ccfm_pkg::ccfm_on_crystal;
    end else begin
      unique case (switch_state)
        ccfm_pkg::ccfm_on_crystal: begin
          if (fail_now) begin
            switch_state <= ccfm_pkg::ccfm_on_safe;
          end
        end
        ccfm_pkg::ccfm_on_safe: begin
          if (switch_back_done) begin
            switch_state <= ccfm_pkg::ccfm_on_crystal;
          end
        end
      endcase
    end
  end

  assign clock_switched_flag =
    (switch_state == ccfm_pkg::ccfm_on_safe);

  // Request bit; a software write beats the hardware clear
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      switch_back_request <= `CCFM_FLAG_RESET;
    end else if (switch_back_write) begin
      switch_back_request <= 1'b1;
    end else if (switch_back_done ||
                 switch_state == ccfm_pkg::ccfm_on_crystal) begin
      switch_back_request <= `CCFM_FLAG_RESET;
    end
  end

  // Registered output clocks, safe source while switched
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      clk_32k_out <= `CCFM_FLAG_RESET;
      clk_1k_out  <= `CCFM_FLAG_RESET;
    end else if (switch_state == ccfm_pkg::ccfm_on_safe) begin
      clk_32k_out <= safe_32k;
      clk_1k_out  <= safe_1k;
    end else begin
      clk_32k_out <= xtal_32k;
      clk_1k_out  <= xtal_1k;
    end
  end

endmodule

// ---- verif/ccfm_chk.sv ----
// Port checker for the crystal clock failure monitor
`timescale 1ns/100ps

module ccfm_chk (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic crystal_enable,
  input wire logic detector_enable,
  input wire logic low_power_safe_osc_32k,
  input wire logic safe_clock_prescale,
  input wire logic interrupt_enable_set_reg,
  input wire logic failure_event_out_enable,
  input wire logic interrupt_flag_clear,
  input wire logic crystal_fail_flag,
  input wire logic interrupt_flag_reg,
  input wire logic fail_irq,
  input wire logic fail_event,
  input wire logic clock_switched_flag,
  input wire logic switch_back_request,
  input wire logic crystal_osc_running,
  input wire logic clk_32k_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_irq_gate: assert property (
    fail_irq == (interrupt_flag_reg && interrupt_enable_set_reg))
    else $error("irq does not follow flag and enable");
  a_off_quiet: assert property (
    !crystal_enable || !detector_enable |=> !crystal_fail_flag && !fail_event)
    else $error("failure reported while monitoring is off");
  a_fail_flags: assert property (
    $rose(crystal_fail_flag) |-> interrupt_flag_reg && clock_switched_flag)
    else $error("failure without flag or switch-over");
  a_fail_event: assert property (
    $rose(crystal_fail_flag) |-> fail_event == $past(failure_event_out_enable))
    else $error("event output does not match its enable");
  a_event_cause: assert property (
    fail_event |-> crystal_fail_flag && $past(failure_event_out_enable)
    ##1 !fail_event)
    else $error("event pulse without failure or too long");
  a_time_select_a_wait: assert property (
    $rose(crystal_fail_flag) |-> $past(crystal_osc_running))
    else $error("failure declared during start-up");
  a_irq_sticky: assert property (
    $fell(interrupt_flag_reg) |-> $past(interrupt_flag_clear))
    else $error("interrupt flag dropped without clear");
  a_back_done: assert property (
    $fell(clock_switched_flag) |-> $past(switch_back_request)
    && !switch_back_request)
    else $error("switch back without request or request kept");
  a_safe_follow: assert property (
    clock_switched_flag && $past(clock_switched_flag, 4) && $past(rst_b, 4)
    && !safe_clock_prescale && !$past(safe_clock_prescale, 4)
    |-> clk_32k_out == $past(low_power_safe_osc_32k, 3))
    else $error("switched output does not follow safe clock");
endmodule

bind ccfm_top ccfm_chk i_ccfm_chk (
  .core_clk, .rst_b, .crystal_enable, .detector_enable,
  .low_power_safe_osc_32k, .safe_clock_prescale, .interrupt_enable_set_reg,
  .failure_event_out_enable, .interrupt_flag_clear, .crystal_fail_flag,
  .interrupt_flag_reg, .fail_irq, .fail_event, .clock_switched_flag,
  .switch_back_request, .crystal_osc_running, .clk_32k_out
);

// ---- verif/ccfm_xtal_model.sv ----
// Behavioural model of the monitored 32 kHz crystal oscillator
`timescale 1ns/100ps

module ccfm_xtal_model (
  input  wire logic run,
  input  var  real  half_ns,
  output logic      osc_32k,
  output logic      osc_1k
);
  int n;

  initial begin
    osc_32k = 1'b0;
    osc_1k  = 1'b0;
    n = 0;
    forever begin
      #(half_ns);
      // A dead crystal leaves both pins standing still
      if (run) begin
        osc_32k = ~osc_32k;
        n++;
        if (n % 8 == 0)
          osc_1k = ~osc_1k;
      end
    end
  end
endmodule

// ---- verif/testbench.sv ----
// Self-checking testbench for the crystal clock failure monitor
`timescale 1ns/100ps

module testbench;
  logic        core_clk, rst_b, xtal_32k, xtal_1k, xtal_run, clk_prev;
  logic        clk1k_prev;
  logic        crystal_enable, crystal_restart, detector_enable;
  logic        safe_clock_prescale, irq_en, ev_en, flag_clr, swb_write;
  logic [3:0]  time_select_a;
  logic [7:0]  sdiv;
  logic        fail_flag, irq_flag, fail_irq, fail_event, switched;
  logic        swb_req, running, clk_32k, clk_1k;
  logic [31:0] lfsr;
  logic [15:0] note_q[$];
  logic [15:0] nt;
  real         xtal_half;
  int          num_errors, n_tests, ev_cnt, per, per_cnt, per1k, per1k_cnt;
  event        snap;
  wire  [5:0]  stat = {fail_flag, irq_flag, fail_irq, switched, swb_req,
                       running};

  ccfm_top i_ccfm_top (
    .core_clk(core_clk), .rst_b(rst_b), .crystal_32k_osc_clk(xtal_32k),
    .crystal_1k_clk(xtal_1k), .low_power_safe_osc_32k(sdiv[2]),
    .low_power_safe_osc_1k(sdiv[4]), .crystal_enable(crystal_enable),
    .crystal_restart(crystal_restart), .time_select_a(time_select_a),
    .detector_enable(detector_enable),
    .safe_clock_prescale(safe_clock_prescale),
    .interrupt_enable_set_reg(irq_en), .failure_event_out_enable(ev_en),
    .interrupt_flag_clear(flag_clr), .switch_back_write(swb_write),
    .crystal_fail_flag(fail_flag), .interrupt_flag_reg(irq_flag),
    .fail_irq(fail_irq), .fail_event(fail_event),
    .clock_switched_flag(switched), .switch_back_request(swb_req),
    .crystal_osc_running(running), .clk_32k_out(clk_32k),
    .clk_1k_out(clk_1k)
  );

  ccfm_xtal_model i_ccfm_xtal_model (
    .run(xtal_run), .half_ns(xtal_half), .osc_32k(xtal_32k), .osc_1k(xtal_1k)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp_bits(input logic [5:0] exp, input logic [5:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: status expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmp_num(input int exp, input int got);
    n_tests++;
    if (got != exp) begin
      num_errors++;
      $display("Error at %0t: count expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Kind 0 status, 1 event count, 2 and 3 periods of 32 kHz and 1 kHz
  task automatic note(input logic [3:0] kind, input logic [11:0] val);
    note_q.push_back({kind, val});
    -> snap;
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick(1);
    sig = 1'b0;
  endtask

  task automatic wait_fail();
    for (int i = 0; i < 400 && fail_flag !== 1'b1; i++)
      tick(1);
    if (fail_flag !== 1'b1) begin
      num_errors++;
      $display("Error at %0t: fail flag expected 1 got %h", $time, fail_flag);
    end
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Safe oscillator: 32 kHz pin period 8 cycles, 1 kHz pin 32 cycles
  always @(posedge core_clk)
    sdiv <= #1 sdiv + 8'h01;

  always @(posedge core_clk) begin
    if (fail_event === 1'b1)
      ev_cnt++;
    per_cnt++;
    per1k_cnt++;
    if (clk_32k === 1'b1 && clk_prev === 1'b0) begin
      per = per_cnt;
      per_cnt = 0;
    end
    if (clk_1k === 1'b1 && clk1k_prev === 1'b0) begin
      per1k = per1k_cnt;
      per1k_cnt = 0;
    end
    clk_prev = clk_32k;
    clk1k_prev = clk_1k;
  end

  initial forever begin
    @snap;
    while (note_q.size() > 0) begin
      nt = note_q.pop_front();
      case (nt[15:12])
        4'h0: cmp_bits(nt[5:0], stat);
        4'h1: cmp_num(int'(nt[11:0]), ev_cnt);
        4'h2: cmp_num(int'(nt[11:0]), per);
        default: cmp_num(int'(nt[11:0]), per1k);
      endcase
    end
  end

  // Sequence needs under 2000 cycles
  initial begin
    #200000;
    num_errors++;
    close_out();
  end

  initial begin
    {rst_b, crystal_enable, crystal_restart, detector_enable} = 4'h0;
    {safe_clock_prescale, irq_en, ev_en, flag_clr, swb_write} = 5'h00;
    {xtal_run, clk_prev, clk1k_prev} = 3'b000;
    time_select_a = 4'h0;
    sdiv = 8'h00;
    {num_errors, n_tests, ev_cnt, per, per_cnt, per1k, per1k_cnt} = '0;
    lfsr = 32'he1d17957;
    xtal_half = 31.3;
    tick(10);
    rst_b = 1'b1;
    tick(2);
    note(0, 12'h000);
    // Safe oscillator runs before detection is armed
    {detector_enable, irq_en, ev_en} = 3'b111;
    tick(200);
    note(0, 12'h000);
    note(1, 12'h000);
    lfsr = lfsr_next(lfsr);
    xtal_half = 21.3 + 8.0 * lfsr[1:0];
    xtal_run = 1'b1;
    crystal_enable = 1'b1;
    tick(300);
    note(0, 12'h001);
    xtal_run = 1'b0;
    wait_fail();
    tick(2);
    note(0, 12'h03d);
    note(1, 12'h001);
    // Long enough for two safe 1 kHz rises after the switch
    tick(80);
    note(2, 12'h008);
    note(3, 12'h020);
    safe_clock_prescale = 1'b1;
    tick(160);
    note(2, 12'h010);
    note(3, 12'h040);
    {irq_en, ev_en} = 2'b00;
    time_select_a = 4'h2;
    lfsr = lfsr_next(lfsr);
    xtal_half = 21.3 + 8.0 * lfsr[1:0];
    xtal_run = 1'b1;
    pulse(crystal_restart);
    tick(1);
    note(0, 12'h014);
    tick(150);
    note(0, 12'h015);
    pulse(flag_clr);
    note(0, 12'h005);
    pulse(swb_write);
    tick(3);
    note(0, 12'h001);
    ev_cnt = 0;
    xtal_run = 1'b0;
    wait_fail();
    tick(2);
    note(0, 12'h035);
    note(1, 12'h000);
    crystal_enable = 1'b0;
    tick(3);
    note(0, 12'h014);
    tick(2);
    close_out();
  end
endmodule
